// file: rtl/cms_seq.sv
`timescale 1ns/10ps
`include "cms_consts.svh"

module cms_seq
  import cms_pkg::*;
#(
  parameter int unsigned CMP2_CYC = 32'd130000,
  parameter int unsigned CMP3_CYC = 32'd1300000,
  parameter int unsigned CMP4_CYC = 32'd5000000,
  parameter int unsigned CMP5_CYC = 32'd5000000,
  parameter int unsigned CMP6_CYC = 32'd5000000,
  parameter int unsigned CMP7_CYC = (`CMS_CMP7_MS * (`CMS_CLK_HZ / 1000)),
  parameter int unsigned WDT_CYC  = (`CMS_WDT_MS * (`CMS_CLK_HZ / 1000)),
  parameter int unsigned CLR_CYC  = (`CMS_CLR_MS * (`CMS_CLK_HZ / 1000)),
  parameter int unsigned DIAG_CYC = (`CMS_DIAG_US * (`CMS_CLK_HZ / 1000000)),
  parameter int unsigned TOG_CYC  = (`CMS_TOG_US * (`CMS_CLK_HZ / 1000000))
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // converter front end
  output logic             adc_req_o,
  output logic [3:0]       adc_chan_o,
  input  wire logic        adc_done_i,
  input  wire logic [11:0] adc_code_i,
  input  wire logic        mux_fail_i,
  // serial link pins
  input  wire logic        serial_clk_i,
  input  wire logic        chip_sel_n_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  // watchdog open-drain pin
  output logic             watchdog_out_n_o,
  output logic             watchdog_oe_o,
  input  wire logic        watchdog_in_i,
  // discharge switches
  output logic [11:0]      discharge_o
);

  cms_state_t  state_q;
  cms_op_t     op_q;
  logic [31:0] cfg_q, lim_q;
  logic [11:0] uv_flag_q, ov_flag_q;
  logic [11:0] diag_ref_q;
  logic        diag_mf_q, ref_got_q;
  logic [11:0] res_q [`CMS_NRES];
  logic [3:0]  chan_q;
  logic [31:0] tmr_q, per_q, wdt_q, tog_q;
  logic [7:0]  win_q;
  logic        wdt_fired_q;
  logic        tog_q_lvl;
  logic        dph_q, dwr_q;
  logic [7:0]  daddr_q;
  logic [31:0] hrdata_q;
  logic [2:0]  sck_s_q, csn_s_q;
  logic [1:0]  wdi_s_q;
  logic        sdo_val_q;

  logic [2:0]  rate;
  logic [11:0] mask, dis_cfg, uv_lim, ov_lim;
  logic        standby, busy, addr_ph, wr_cmd, cmd_ok, start_ok, any_wr;
  logic        last_chan, gate_on;
  cms_op_t     cmd_op;

  assign rate    = cfg_q[`CMS_CFG_RATE_LSB +: 3];
  assign mask    = cfg_q[`CMS_CFG_MASK_LSB +: 12];
  assign dis_cfg = cfg_q[`CMS_CFG_DIS_LSB +: 12];
  assign uv_lim  = lim_q[11:0];
  assign ov_lim  = lim_q[`CMS_LIM_OV_LSB +: 12];
  assign standby = (rate == 3'h0);
  assign busy    = (state_q != CMS_IDLE);

  // interval of the periodic check for each rate
  function automatic logic [31:0] cmp_cyc(input logic [2:0] r);
    cmp_cyc = (r == 3'h2) ? CMP2_CYC : (r == 3'h3) ? CMP3_CYC :
              (r == 3'h4) ? CMP4_CYC : (r == 3'h5) ? CMP5_CYC :
              (r == 3'h6) ? CMP6_CYC : CMP7_CYC;
  endfunction : cmp_cyc

  // cell channel in use: not masked and not cut by ten-cell select
  function automatic logic chan_used(input logic [3:0] c, input logic [11:0] m,
                                     input logic ten);
    chan_used = !m[c] && !(ten && (c >= 4'(`CMS_NTEN)));
  endfunction : chan_used

  assign addr_ph     = hsel_i && hready_i && htrans_i[1];
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = hrdata_q;
  assign any_wr      = dph_q && dwr_q;
  assign wr_cmd      = any_wr && (daddr_q == `CMS_OFF_CMD);
  assign cmd_ok      = hwdata_i[`CMS_CMD_OK_BIT];
  assign cmd_op      = cms_op_t'(hwdata_i[3:0]);
  // a start is taken only when idle, in measure mode, check bit set, outside window
  assign start_ok    = wr_cmd && cmd_ok && !busy && !standby && (win_q == 8'h00);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      dph_q   <= 1'b0;
      dwr_q   <= 1'b0;
      daddr_q <= 8'h00;
    end else begin
      dph_q   <= addr_ph;
      dwr_q   <= hwrite_i;
      daddr_q <= {haddr_i[7:2], 2'b00};
    end
  end

  // read data captured in the address phase, so the data phase needs no wait
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addr_ph && !hwrite_i) begin
      if (haddr_i[7:2] == `CMS_OFF_CFG >> 2) begin
        hrdata_q <= cfg_q;
      end else if (haddr_i[7:2] == `CMS_OFF_LIM >> 2) begin
        hrdata_q <= lim_q;
      end else if (haddr_i[7:2] == `CMS_OFF_STAT >> 2) begin
        hrdata_q <= {27'h0, sdo_val_q, wdi_s_q[1], !wdt_fired_q, |{uv_flag_q, ov_flag_q},
                     busy};
      end else if (haddr_i[7:2] == `CMS_OFF_FLAG >> 2) begin
        hrdata_q <= {4'h0, ov_flag_q, 4'h0, uv_flag_q};
      end else if (haddr_i[7:2] == `CMS_OFF_DIAG >> 2) begin
        hrdata_q <= {19'h0, diag_mf_q, diag_ref_q};
      end else if (haddr_i >= `CMS_OFF_RES0 && haddr_i <= `CMS_OFF_RESN) begin
        hrdata_q <= {20'h0, res_q[4'(haddr_i[7:2] - 6'h10)]};
      end else begin
        hrdata_q <= 32'h0000_0000;
      end
    end
  end

  // configuration; watchdog expiry restores the power-up configuration word, limits are kept
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_q <= `CMS_CFG_RST;
      lim_q <= `CMS_LIM_RST;
    end else if (!standby && wdt_q >= WDT_CYC) begin
      cfg_q <= `CMS_CFG_RST;
    end else if (any_wr && daddr_q == `CMS_OFF_CFG) begin
      cfg_q <= hwdata_i;
    end else if (any_wr && daddr_q == `CMS_OFF_LIM) begin
      lim_q <= {4'h0, hwdata_i[27:16], 4'h0, hwdata_i[11:0]};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_q       <= 32'h0;
      wdt_fired_q <= 1'b0;
    end else if (any_wr && !(wr_cmd && !cmd_ok)) begin
      wdt_q       <= 32'h0;
      wdt_fired_q <= 1'b0;
    end else if (standby) begin
      wdt_q <= 32'h0;
    end else if (wdt_q >= WDT_CYC) begin
      wdt_q       <= 32'h0;
      wdt_fired_q <= 1'b1;
    end else begin
      wdt_q <= wdt_q + 32'h1;
    end
  end

  assign watchdog_out_n_o = 1'b0;
  assign watchdog_oe_o    = wdt_fired_q;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wdi_s_q <= 2'b11;
    end else begin
      wdi_s_q <= {wdi_s_q[0], watchdog_in_i};
    end
  end

  // period runs through scans so the interval holds; a trigger met while busy is skipped
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      per_q <= 32'h0;
    end else if (rate < 3'h2) begin
      per_q <= 32'h0;
    end else if (per_q >= cmp_cyc(rate) - 32'h1) begin
      per_q <= 32'h0;
    end else begin
      per_q <= per_q + 32'h1;
    end
  end

  // start of each check cycle opens a short blind window for starts
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      win_q <= 8'h00;
    end else if (state_q == CMS_IDLE && rate >= 3'h2 && per_q >= cmp_cyc(rate) - 32'h1) begin
      win_q <= 8'(`CMS_WIN_CYC);
    end else if (win_q != 8'h00) begin
      win_q <= win_q - 8'h01;
    end
  end

  assign last_chan = (chan_q == 4'(`CMS_NCELL - 1));

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= CMS_IDLE;
      op_q    <= CMS_OP_NONE;
      chan_q  <= 4'h0;
      tmr_q   <= 32'h0;
    end else if (standby) begin
      state_q <= CMS_IDLE;
      op_q    <= CMS_OP_NONE;
    end else begin
      case (state_q)
        CMS_IDLE: begin
          chan_q <= 4'h0;
          tmr_q  <= 32'h0;
          if (start_ok) begin
            op_q <= cmd_op;
            if (cmd_op == CMS_OP_CLR || cmd_op == CMS_OP_DIAG) begin
              state_q <= CMS_TIMED;
            end else if (cmd_op != CMS_OP_NONE && cmd_op != CMS_OP_CMP) begin
              state_q <= CMS_WALK;
            end
          end else if (rate >= 3'h2 && per_q >= cmp_cyc(rate) - 32'h1) begin
            op_q    <= CMS_OP_CMP;
            state_q <= CMS_WALK;
          end
        end
        CMS_WALK: begin
          if (chan_used(chan_q, mask, cfg_q[`CMS_CFG_TEN_BIT])) begin
            state_q <= CMS_WAIT;
          end else if (last_chan) begin
            state_q <= CMS_IDLE;
          end else begin
            chan_q <= chan_q + 4'h1;
          end
        end
        CMS_WAIT: begin
          if (adc_done_i) begin
            if (last_chan) begin
              state_q <= CMS_IDLE;
            end else begin
              chan_q  <= chan_q + 4'h1;
              state_q <= CMS_WALK;
            end
          end
        end
        CMS_TIMED: begin
          tmr_q <= tmr_q + 32'h1;
          if ((op_q == CMS_OP_CLR && tmr_q >= CLR_CYC - 32'h1) ||
              (op_q == CMS_OP_DIAG && tmr_q >= DIAG_CYC - 32'h1)) begin
            state_q <= CMS_IDLE;
          end
        end
        default: begin
          state_q <= CMS_IDLE;
        end
      endcase
    end
  end

  // the reference is converted once at the start of a diagnose
  assign adc_req_o  = !standby && ((state_q == CMS_WAIT) ||
                      (state_q == CMS_TIMED && op_q == CMS_OP_DIAG && !ref_got_q));
  assign adc_chan_o = (state_q == CMS_TIMED) ? `CMS_REF_CHAN : chan_q;

  // results: codes stored raw, already offset binary from the converter
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < `CMS_NRES; i++) begin
        res_q[i] <= `CMS_CLR_CODE;
      end
    end else if (!standby && state_q == CMS_TIMED && op_q == CMS_OP_CLR && tmr_q == 32'h0) begin
      for (int i = 0; i < `CMS_NRES; i++) begin
        res_q[i] <= `CMS_CLR_CODE;
      end
    end else if (!standby && state_q == CMS_WAIT && adc_done_i) begin
      if (op_q == CMS_OP_ST1 || op_q == CMS_OP_ST2) begin
        if (last_chan) begin
          for (int i = 0; i < `CMS_NRES; i++) begin
            res_q[i] <= (op_q == CMS_OP_ST1) ? `CMS_ST1_CODE : `CMS_ST2_CODE;
          end
        end
      end else if (op_q != CMS_OP_CMP) begin
        res_q[chan_q] <= adc_code_i;
      end
    end
  end

  // flags refreshed by every cell conversion outside the self-tests and by every periodic check
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      uv_flag_q <= 12'h000;
      ov_flag_q <= 12'h000;
    end else if (state_q == CMS_WALK && !chan_used(chan_q, mask, cfg_q[`CMS_CFG_TEN_BIT])) begin
      uv_flag_q[chan_q] <= 1'b0;
      ov_flag_q[chan_q] <= 1'b0;
    end else if (!standby && state_q == CMS_WAIT && adc_done_i &&
                 op_q != CMS_OP_ST1 && op_q != CMS_OP_ST2) begin
      uv_flag_q[chan_q] <= (adc_code_i < uv_lim);
      ov_flag_q[chan_q] <= (adc_code_i > ov_lim);
    end
  end

  // diagnostic register; reference request held until its code arrives
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      diag_ref_q <= 12'h000;
      diag_mf_q  <= 1'b0;
      ref_got_q  <= 1'b0;
    end else if (!standby && state_q == CMS_TIMED && op_q == CMS_OP_DIAG) begin
      if (!ref_got_q && adc_done_i) begin
        diag_ref_q <= adc_code_i;
        ref_got_q  <= 1'b1;
      end
      if (tmr_q >= DIAG_CYC - 32'h1) begin
        diag_mf_q <= mux_fail_i;
      end
    end else begin
      ref_got_q <= 1'b0;
    end
  end

  assign gate_on = (state_q == CMS_WAIT) &&
                   (op_q == CMS_OP_CELL || op_q == CMS_OP_OW || op_q == CMS_OP_CMP);

  always_comb begin
    discharge_o = dis_cfg;
    if (gate_on) begin
      discharge_o[chan_q] = 1'b0;
      if (chan_q != 4'h0) begin
        discharge_o[chan_q - 4'h1] = 1'b0;
      end
      if (!last_chan) begin
        discharge_o[chan_q + 4'h1] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sck_s_q <= 3'b111;
      csn_s_q <= 3'b111;
    end else begin
      sck_s_q <= {sck_s_q[1:0], serial_clk_i};
      csn_s_q <= {csn_s_q[1:0], chip_sel_n_i};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tog_q     <= 32'h0;
      tog_q_lvl <= 1'b0;
    end else if (tog_q >= TOG_CYC - 32'h1) begin
      tog_q     <= 32'h0;
      tog_q_lvl <= !tog_q_lvl;
    end else begin
      tog_q <= tog_q + 32'h1;
    end
  end

  // good state: high in level mode, 1kHz wave in toggle mode; busy or fault pulls low
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_val_q <= 1'b1;
    end else if (sck_s_q[2] && !sck_s_q[1]) begin
      if (busy || |{uv_flag_q, ov_flag_q}) begin
        sdo_val_q <= 1'b0;
      end else begin
        sdo_val_q <= cfg_q[`CMS_CFG_LVL_BIT] ? 1'b1 : tog_q_lvl;
      end
    end
  end

  assign sdo_o    = 1'b0;
  assign sdo_oe_o = !csn_s_q[1] && !sdo_val_q;

endmodule : cms_seq

// file: rtl/cms_consts.svh
`ifndef CMS_CONSTS_SVH
`define CMS_CONSTS_SVH

// register byte offsets
`define CMS_OFF_CFG     8'h00
`define CMS_OFF_LIM     8'h04
`define CMS_OFF_CMD     8'h08
`define CMS_OFF_STAT    8'h0C
`define CMS_OFF_FLAG    8'h10
`define CMS_OFF_DIAG    8'h14
`define CMS_OFF_RES0    8'h40
`define CMS_OFF_RESN    8'h78

// configuration, limit, command and diagnostic word fields
`define CMS_CFG_RATE_LSB 0
`define CMS_CFG_TEN_BIT  3
`define CMS_CFG_LVL_BIT  4
`define CMS_CFG_MASK_LSB 8
`define CMS_CFG_DIS_LSB  20
`define CMS_LIM_OV_LSB   16
`define CMS_CMD_OK_BIT   8
`define CMS_DIAG_MF_BIT  12

// reset values
`define CMS_CFG_RST     32'h0000_0000
`define CMS_LIM_RST     32'h0000_0000

// codes and counts
`define CMS_ZERO_CODE   12'h200
`define CMS_CLR_CODE    12'hFFF
`define CMS_ST1_CODE    12'h555
`define CMS_ST2_CODE    12'hAAA
`define CMS_NCELL       12
`define CMS_NTEN        10
`define CMS_NRES        15
`define CMS_REF_CHAN    4'hF

// timing, figures in their own units
`define CMS_CLK_HZ      10000000
`define CMS_CMP7_MS     2000
`define CMS_WDT_MS      1500
`define CMS_CLR_MS      1
`define CMS_DIAG_US     16400
`define CMS_TOG_US      500
`define CMS_WIN_US      5
`define CMS_WIN_CYC     ((`CMS_WIN_US * `CMS_CLK_HZ) / 1000000)

`endif

// file: rtl/cms_pkg.sv
package cms_pkg;

  typedef enum logic [2:0] {
    CMS_IDLE  = 3'b000,
    CMS_WALK  = 3'b001,
    CMS_WAIT  = 3'b010,
    CMS_TIMED = 3'b011
  } cms_state_t;

  typedef enum logic [3:0] {
    CMS_OP_NONE = 4'h0,
    CMS_OP_CELL = 4'h1,
    CMS_OP_OW   = 4'h2,
    CMS_OP_CELK = 4'h3,
    CMS_OP_OWK  = 4'h4,
    CMS_OP_CLR  = 4'h6,
    CMS_OP_ST1  = 4'h7,
    CMS_OP_ST2  = 4'h8,
    CMS_OP_DIAG = 4'h9,
    CMS_OP_CMP  = 4'hF
  } cms_op_t;

endpackage : cms_pkg

// file: testbench/cms_seq_properties.sv
`timescale 1ns/10ps
`include "cms_consts.svh"
module cms_seq_properties (
  // clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rst_i,
  // bus
  input wire logic        hsel_i,
  input wire logic [7:0]  haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic        hready_i,
  // converter and pins
  input wire logic        adc_req_o,
  input wire logic [3:0]  adc_chan_o,
  input wire logic        adc_done_i,
  input wire logic        chip_sel_n_i,
  input wire logic        sdo_o,
  input wire logic        sdo_oe_o,
  input wire logic        watchdog_out_n_o,
  input wire logic        watchdog_oe_o,
  input wire logic [11:0] discharge_o
);
  logic        wr_ap_q;
  logic [7:0]  wr_addr_q;
  logic [2:0]  rate_q;
  logic        norm_q;
  logic [13:0] gate_win;

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ap_q   <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_ap_q   <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      wr_addr_q <= haddr_i;
    end
  end
  // shadow of the rate field; blind to watchdog clears, which only loses checks
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rate_q <= 3'h0;
    end else if (wr_ap_q && hready_i && wr_addr_q == `CMS_OFF_CFG) begin
      rate_q <= hwdata_i[2:0];
    end
  end
  // gating is claimed from reset and after a plain cell or open-wire command
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      norm_q <= 1'b1;
    end else if (wr_ap_q && hready_i && wr_addr_q == `CMS_OFF_CMD && hwdata_i[`CMS_CMD_OK_BIT]) begin
      norm_q <= (hwdata_i[3:0] == 4'h1) || (hwdata_i[3:0] == 4'h2);
    end
  end
  assign gate_win = 14'h0007 << adc_chan_o;

  a_reset_quiet: assert property ($fell(rst_i) |-> !adc_req_o && discharge_o == 12'h000
    && !sdo_oe_o && !watchdog_oe_o) else $error("outputs not quiet after reset");
  a_standby_idle: assert property (rate_q == 3'h0 [*2] |-> !adc_req_o)
    else $error("converter requested in standby");
  a_chan_hold: assert property (adc_req_o && !adc_done_i ##1 adc_req_o |-> $stable(adc_chan_o))
    else $error("channel changed before done");
  a_chan_legal: assert property (adc_req_o |-> adc_chan_o < 4'hC || adc_chan_o == `CMS_REF_CHAN)
    else $error("illegal channel requested");
  a_gate_cell: assert property (adc_req_o && adc_chan_o < 4'hC && norm_q |->
    (discharge_o & gate_win[12:1]) == 12'h000) else $error("switch on near measured cell");
  a_done_drop: assert property (adc_req_o && adc_done_i |=> !adc_req_o)
    else $error("request held after done");
  a_wdt_drain: assert property (watchdog_oe_o |-> !watchdog_out_n_o)
    else $error("watchdog pin driven high");
  a_sdo_drain: assert property (sdo_oe_o |-> !sdo_o)
    else $error("sdo driven high");
  a_sdo_release: assert property (chip_sel_n_i [*8] |-> !sdo_oe_o)
    else $error("sdo driven while deselected");

  c_adc_done: cover property (adc_req_o && adc_done_i);
  c_periodic: cover property (rate_q == 3'h7 && adc_req_o);
  c_watchdog: cover property (watchdog_oe_o);
endmodule : cms_seq_properties

bind cms_seq cms_seq_properties i_props (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
  .adc_req_o(adc_req_o), .adc_chan_o(adc_chan_o), .adc_done_i(adc_done_i),
  .chip_sel_n_i(chip_sel_n_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
  .watchdog_out_n_o(watchdog_out_n_o), .watchdog_oe_o(watchdog_oe_o),
  .discharge_o(discharge_o)
);

// file: testbench/cms_host_model.sv
`timescale 1ns/10ps
module cms_host_model (
  // control from bench
  input  wire logic frame_i,
  input  wire logic sdo_line_i,
  // serial pins
  output logic      serial_clk_o,
  output logic      chip_sel_n_o,
  output logic      sdo_bit_o
);
  // clock idles high and stands still between frames
  initial begin
    serial_clk_o = 1'b1;
    chip_sel_n_o = 1'b1;
    sdo_bit_o    = 1'b1;
    #37;
    forever begin
      wait (frame_i === 1'b1);
      #400 chip_sel_n_o = 1'b0;
      while (frame_i === 1'b1) begin
        #400 serial_clk_o = 1'b0;
        #400 serial_clk_o = 1'b1;
        sdo_bit_o = sdo_line_i;
      end
      #400 chip_sel_n_o = 1'b1;
    end
  end
endmodule : cms_host_model

// file: testbench/tb.sv
`timescale 1ns/10ps
`include "cms_consts.svh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import cms_pkg::*;
  localparam int unsigned CMPN = 400;
  localparam int unsigned CMP7 = 600;
  localparam int unsigned WDT  = 3000;
  localparam int unsigned CLR  = 20;
  logic        clk_sys_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        hsel      = 1'b0;
  logic [7:0]  haddr     = 8'h00;
  logic [1:0]  htrans    = 2'b00;
  logic        hwrite    = 1'b0;
  logic [31:0] hwdata    = 32'h0;
  logic        adc_done  = 1'b0;
  logic [11:0] adc_code  = 12'h000;
  logic        mux_fail  = 1'b0;
  logic        frame     = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout, adc_req, sclk, csn, sdo, sdo_oe, wd_n, wd_oe, sdo_bit;
  logic [3:0]  adc_chan;
  logic [11:0] dis;
  int          lat = 2, wcnt = 0, cyc = 0, n_fail = 0, compares = 0;

  always #50 clk_sys_i = ~clk_sys_i;

  cms_seq #(.CMP2_CYC(CMPN), .CMP3_CYC(CMPN), .CMP4_CYC(CMPN), .CMP5_CYC(CMPN),
    .CMP6_CYC(CMPN), .CMP7_CYC(CMP7), .WDT_CYC(WDT), .CLR_CYC(CLR), .DIAG_CYC(40),
    .TOG_CYC(5)) i_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(),
    .adc_req_o(adc_req), .adc_chan_o(adc_chan), .adc_done_i(adc_done),
    .adc_code_i(adc_code), .mux_fail_i(mux_fail), .serial_clk_i(sclk),
    .chip_sel_n_i(csn), .sdo_o(sdo), .sdo_oe_o(sdo_oe), .watchdog_out_n_o(wd_n),
    .watchdog_oe_o(wd_oe), .watchdog_in_i(wd_oe ? wd_n : 1'b1), .discharge_o(dis));

  // open-drain sdo with pull-up seen by the host
  cms_host_model i_host (.frame_i(frame), .sdo_line_i(sdo_oe ? sdo : 1'b1),
    .serial_clk_o(sclk), .chip_sel_n_o(csn), .sdo_bit_o(sdo_bit));

  function automatic logic [11:0] code_of(input logic [3:0] ch);
    return (ch == `CMS_REF_CHAN) ? 12'h6AA : 12'h200 + {4'h0, ch, 4'h0} * 12'h00C;
  endfunction : code_of

  // converter front end; lat sets a prompt or slow answer
  always @(posedge clk_sys_i) begin
    adc_done <= 1'b0;
    if (adc_req === 1'b1 && adc_done === 1'b0) begin
      wcnt <= (wcnt >= lat) ? 0 : wcnt + 1;
      if (wcnt >= lat) begin
        adc_done <= 1'b1;
        adc_code <= code_of(adc_chan);
      end
    end
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end

  task automatic summarize();
    if (n_fail == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, 1'b1, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(a, 1'b0, 32'h0, q);
  endtask : rd

  task automatic cmd(input cms_op_t op, input logic ok = 1'b1);
    wr(`CMS_OFF_CMD, {23'h0, ok, 4'h0, op});
  endtask : cmd

  task automatic wait_idle();
    logic [31:0] s;
    int k;
    s = 32'h1;
    for (k = 0; k < 3000 && s[0] !== 1'b0; k++) rd(`CMS_OFF_STAT, s);
    if (s[0] !== 1'b0) n_fail++;
  endtask : wait_idle

  // every result word against one value, or cell codes when all is 0, with temps and blank cells cleared
  task automatic chk_res(input logic [11:0] all, input logic [14:0] blank);
    logic [31:0] v;
    for (int i = 0; i < 15; i++) begin
      rd(`CMS_OFF_RES0 + 8'(4 * i), v);
      if (all != 12'h000) `CHK(v[11:0], all)
      else `CHK(v[11:0], (i > 11 || blank[i]) ? 12'hFFF : code_of(4'(i)))
    end
  endtask : chk_res

  task automatic wait_scan(output int t);
    logic p;
    p = 1'b1;
    t = -1;
    for (int k = 0; k < 1500 && t < 0; k++) begin
      @(posedge clk_sys_i);
      if (adc_req === 1'b1 && adc_chan === 4'h0 && p === 1'b0) t = cyc;
      p = adc_req;
    end
  endtask : wait_scan

  task automatic t_reset();
    logic [31:0] v;
    rd(`CMS_OFF_CFG, v);
    `CHK(v, `CMS_CFG_RST)
    rd(`CMS_OFF_LIM, v);
    `CHK(v, `CMS_LIM_RST)
    `CHK(dis, 12'h000)
    chk_res(`CMS_CLR_CODE, 15'h0);
    cmd(CMS_OP_CELL);
    repeat (30) @(posedge clk_sys_i);
    `CHK(adc_req, 1'b0)
  endtask : t_reset

  task automatic t_convert();
    logic [31:0] v;
    wr(`CMS_OFF_LIM, 32'h0980_0280);
    wr(`CMS_OFF_CFG, 32'hFFF0_0011);
    lat = 9;
    frame = 1'b1;
    repeat (20) @(posedge clk_sys_i);
    `CHK(sdo_bit, 1'b1)
    cmd(CMS_OP_CELL);
    cmd(CMS_OP_CLR); // dropped while busy
    repeat (40) @(posedge clk_sys_i);
    `CHK(sdo_bit, 1'b0)
    rd(`CMS_OFF_STAT, v);
    `CHK(v[0], 1'b1)
    wait_idle();
    frame = 1'b0;
    lat = 2;
    chk_res(12'h000, 15'h0);
    rd(`CMS_OFF_FLAG, v);
    `CHK(v, 32'h0800_0001)
  endtask : t_convert

  task automatic t_periodic();
    int t1, t2;
    logic [31:0] v;
    wr(`CMS_OFF_LIM, 32'h0FFF_0100);
    for (int r = 2; r < 7; r++) begin
      wr(`CMS_OFF_CFG, 32'hFFF0_0000 | r);
      wait_scan(t1);
      `CHK(t1 >= 0, 1'b1)
    end
    wr(`CMS_OFF_CFG, 32'hFFF0_0007);
    wait_scan(t1);
    wait_scan(t2);
    `CHK((t2 - t1 >= CMP7 - 1) && (t2 - t1 <= CMP7 + 1), 1'b1)
    wr(`CMS_OFF_CFG, 32'hFFF0_0001);
    repeat (100) @(posedge clk_sys_i);
    rd(`CMS_OFF_FLAG, v);
    `CHK(v, 32'h0)
  endtask : t_periodic

  task automatic t_mask();
    logic [31:0] v;
    wr(`CMS_OFF_LIM, 32'h0980_0280);
    wr(`CMS_OFF_CFG, 32'hFFF0_2019);
    cmd(CMS_OP_CLR);
    wait_idle();
    cmd(CMS_OP_CELL, 1'b0);
    repeat (30) @(posedge clk_sys_i);
    rd(`CMS_OFF_RES0, v);
    `CHK(v[11:0], `CMS_CLR_CODE)
    cmd(CMS_OP_CELL);
    wait_idle();
    chk_res(12'h000, 15'h0C20);
    rd(`CMS_OFF_FLAG, v);
    `CHK(v, 32'h0000_0001)
  endtask : t_mask

  task automatic t_keep();
    logic bad;
    logic [11:0] g;
    wr(`CMS_OFF_CFG, 32'hFFF0_0001);
    bad = 1'b0;
    cmd(CMS_OP_CELK);
    repeat (200) @(posedge clk_sys_i) if (adc_req === 1'b1 && dis !== 12'hFFF) bad = 1'b1;
    `CHK(bad, 1'b0)
    g = 12'h000;
    cmd(CMS_OP_OW);
    repeat (200) @(posedge clk_sys_i) if (adc_req === 1'b1 && adc_chan === 4'h5) g = dis;
    `CHK(g, 12'hF8F)
    `CHK(dis, 12'hFFF)
  endtask : t_keep

  task automatic t_tests();
    logic [31:0] v;
    for (int k = 0; k < 2; k++) begin
      cmd(k ? CMS_OP_ST2 : CMS_OP_ST1);
      wait_idle();
      chk_res(k ? `CMS_ST2_CODE : `CMS_ST1_CODE, 15'h0);
      @(posedge clk_sys_i) mux_fail <= (k == 0);
      cmd(CMS_OP_DIAG);
      wait_idle();
      rd(`CMS_OFF_DIAG, v);
      `CHK(v[12:0], {k == 0, code_of(`CMS_REF_CHAN)})
    end
    cmd(CMS_OP_CLR);
    repeat (CLR + 6) @(posedge clk_sys_i);
    rd(`CMS_OFF_STAT, v);
    `CHK(v[0], 1'b0)
    chk_res(`CMS_CLR_CODE, 15'h0);
  endtask : t_tests

  task automatic t_abort_wdt();
    logic [31:0] v;
    int n;
    lat = 9;
    cmd(CMS_OP_CELL);
    repeat (20) @(posedge clk_sys_i);
    wr(`CMS_OFF_CFG, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK(adc_req, 1'b0)
    rd(`CMS_OFF_STAT, v);
    `CHK(v[0], 1'b0)
    lat = 2;
    wr(`CMS_OFF_CFG, 32'hFFF0_0001);
    n = 0;
    repeat (WDT + 20) @(posedge clk_sys_i) if (adc_req === 1'b1) n++;
    `CHK(n, 0)
    `CHK(wd_oe, 1'b1)
    `CHK(dis, 12'h000)
    rd(`CMS_OFF_STAT, v);
    `CHK(v[3:2], 2'b00)
    rd(`CMS_OFF_CFG, v);
    `CHK(v, `CMS_CFG_RST)
    wr(`CMS_OFF_LIM, 32'h0);
    repeat (2) @(posedge clk_sys_i);
    `CHK(wd_oe, 1'b0)
  endtask : t_abort_wdt

  initial begin
    repeat (12) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    t_reset();
    t_convert();
    t_periodic();
    t_mask();
    t_keep();
    t_tests();
    t_abort_wdt();
    summarize();
  end
endmodule : tb
